// ---- core/sfl_front.sv ----
/*
  Serial flash command front end: frames commands on chip select,
  gates writes by the write-guard pin, decodes page and byte addresses
  and streams the legacy continuous array read from the array port.
  Assumes the array answers ARRAY_DATA combinationally from ARRAY_PAGE
  and ARRAY_BYTE within half a serial clock; SCK stops between frames.
*/
`timescale 1ns/1ps
module sfl_front #(
  parameter logic [255:0] WRITE_OPC_MAP =
    256'h00000000_00000000_00000000_0000ffff_00000000_00000000_00000000_00000000,
  parameter logic [255:0] PROT_OPC_MAP =
    256'h00000000_00000000_00000000_00000000_00000000_00000000_20000000_00000000
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  input wire logic WP_N,
  input wire logic RESET_N,
  input wire logic PAGE_BIN,
  output logic [10:0] ARRAY_PAGE,
  output logic [8:0] ARRAY_BYTE,
  output logic ARRAY_RD,
  input wire logic [7:0] ARRAY_DATA,
  output logic CMD_STROBE,
  output logic [7:0] CMD_OPCODE,
  output logic CMD_WRITE,
  output logic CMD_BLOCKED,
  output logic CMD_PROTECT,
  output logic ADDR_STROBE,
  output logic [10:0] ADDR_PAGE,
  output logic [8:0] ADDR_BYTE,
  output logic [8:0] ADDR_BUF_BYTE,
  output logic PROT_REG_LOCK,
  output logic STANDBY,
  output logic CORE_RESET
);
  // Reference domain signals
  logic rstn_s1_q, rstn_s2_q;
  logic wp_r1_q, wp_r2_q;
  logic cs_r1_q, cs_r2_q;
  logic [5:0] por_cnt_q;
  logic core_rst_q;
  logic [2:0] opc_tg_r_q, adr_tg_r_q;
  // Link domain signals
  logic rs1_q, rs2_q;
  logic wp_s1_q, wp_s2_q;
  logic pb_s1_q, pb_s2_q;
  sfl_front_pkg::link_state_t state_q;
  logic [5:0] cnt_q;
  logic [6:0] sh_q;
  logic [2:0] bit_q;
  logic opc_tg_q, adr_tg_q;
  logic [7:0] opc_word_q;
  logic opc_wr_q, opc_blk_q, opc_prot_q;
  logic [10:0] adr_page_q;
  logic [8:0] adr_byte_q, adr_buf_q;
  logic [7:0] so_sh_q;
  logic [7:0] opc_now;
  logic [23:0] adr_now;
  logic [10:0] dec_page;
  logic [8:0] dec_byte, dec_buf, byte_last;
  logic is_write, is_prot;

  // Reset pin and chip select cross into the reference domain
  always_ff @(posedge REF_CLK) begin
    rstn_s1_q <= RESET_N;
    rstn_s2_q <= rstn_s1_q;
    wp_r1_q <= WP_N;
    wp_r2_q <= wp_r1_q;
    cs_r1_q <= CS_N;
    cs_r2_q <= cs_r1_q;
  end

  // Power-on stretch; counts from RST release whatever the reset pin does
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      por_cnt_q <= '0;
    end else if (por_cnt_q != sfl_front_pkg::POR_COUNT) begin
      por_cnt_q <= por_cnt_q + 6'h01;
    end
  end

  // Combined reset level for the link side and the report strobes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= (por_cnt_q != sfl_front_pkg::POR_COUNT) || !rstn_s2_q;
    end
  end

  assign CORE_RESET = core_rst_q;

  // Protection register write gate and standby indication
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PROT_REG_LOCK <= 1'b0;
      STANDBY <= 1'b1;
    end else begin
      PROT_REG_LOCK <= !wp_r2_q;
      STANDBY <= cs_r2_q;
    end
  end

  // Reset level and static pins into the link domain
  always_ff @(posedge SCK) begin
    rs1_q <= core_rst_q;
    rs2_q <= rs1_q;
    wp_s1_q <= WP_N;
    wp_s2_q <= wp_s1_q;
    pb_s1_q <= PAGE_BIN;
    pb_s2_q <= pb_s1_q;
  end

  // Words as they complete on the current rising edge
  assign opc_now = {sh_q, SI};
  assign adr_now = {adr_page_q[2:0], adr_byte_q, adr_buf_q[3:0], sh_q, SI};
  assign is_write = WRITE_OPC_MAP[opc_now];
  assign is_prot = PROT_OPC_MAP[opc_now];
  assign byte_last = pb_s2_q ? sfl_front_pkg::BIN_BYTE_LAST : sfl_front_pkg::STD_BYTE_LAST;

  // Page-size split; upper bits of the address word are don't-care
  always_comb begin
    if (pb_s2_q) begin
      dec_page = adr_now[sfl_front_pkg::BIN_PAGE_LSB +: sfl_front_pkg::PAGE_W];
      dec_byte = {1'b0, adr_now[7:0]};
      dec_buf = {1'b0, adr_now[7:0]};
    end else begin
      dec_page = adr_now[sfl_front_pkg::STD_PAGE_LSB +: sfl_front_pkg::PAGE_W];
      dec_byte = adr_now[sfl_front_pkg::BYTE_W-1:0];
      dec_buf = adr_now[8:0];
    end
  end

  // Frame sequencer; chip select high clears the frame at once
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      state_q <= sfl_front_pkg::ST_OPC;
      cnt_q <= '0;
    end else if (rs2_q) begin
      state_q <= sfl_front_pkg::ST_DROP;
      cnt_q <= '0;
    end else begin
      if (cnt_q != sfl_front_pkg::DUMMY_LAST_BIT) begin
        cnt_q <= cnt_q + 6'h01;
      end
      unique case (state_q)
        sfl_front_pkg::ST_OPC: begin
          if (cnt_q == sfl_front_pkg::OPC_LAST_BIT) begin
            if (is_write && !is_prot && !wp_s2_q) begin
              state_q <= sfl_front_pkg::ST_DROP;
            end else begin
              state_q <= sfl_front_pkg::ST_ADDR;
            end
          end
        end
        sfl_front_pkg::ST_ADDR: begin
          if (cnt_q == sfl_front_pkg::ADDR_LAST_BIT) begin
            if (opc_word_q == sfl_front_pkg::OPC_CONT_READ) begin
              state_q <= sfl_front_pkg::ST_DUMMY;
            end else begin
              state_q <= sfl_front_pkg::ST_DROP;
            end
          end
        end
        sfl_front_pkg::ST_DUMMY: begin
          if (cnt_q == sfl_front_pkg::DUMMY_LAST_BIT) begin
            state_q <= sfl_front_pkg::ST_DATA;
          end
        end
        sfl_front_pkg::ST_DATA: begin
          state_q <= sfl_front_pkg::ST_DATA;
        end
        sfl_front_pkg::ST_DROP: begin
          state_q <= sfl_front_pkg::ST_DROP;
        end
        default: begin
          state_q <= sfl_front_pkg::ST_DROP;
        end
      endcase
    end
  end

  // Input shifter, sampled on the rising edge only
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      sh_q <= '0;
    end else begin
      sh_q <= {sh_q[5:0], SI};
    end
  end

  // Opcode capture; held past the frame so the crossing sees it steady
  always_ff @(posedge SCK) begin
    if (rs2_q) begin
      opc_tg_q <= 1'b0;
      opc_word_q <= '0;
      opc_wr_q <= 1'b0;
      opc_blk_q <= 1'b0;
      opc_prot_q <= 1'b0;
    end else if (!CS_N && state_q == sfl_front_pkg::ST_OPC &&
                 cnt_q == sfl_front_pkg::OPC_LAST_BIT) begin
      opc_tg_q <= !opc_tg_q;
      opc_word_q <= opc_now;
      opc_prot_q <= is_prot;
      opc_wr_q <= is_write && !is_prot && wp_s2_q;
      opc_blk_q <= is_write && !is_prot && !wp_s2_q;
    end
  end

  // Address capture into the page, byte and buffer fields
  always_ff @(posedge SCK) begin
    if (rs2_q) begin
      adr_tg_q <= 1'b0;
      adr_page_q <= '0;
      adr_byte_q <= '0;
      adr_buf_q <= '0;
    end else if (!CS_N && state_q == sfl_front_pkg::ST_ADDR) begin
      // Shift the three address bytes through the holding fields
      adr_page_q <= {adr_page_q[9:0], adr_byte_q[8]};
      adr_byte_q <= {adr_byte_q[7:0], adr_buf_q[3]};
      adr_buf_q <= {adr_buf_q[7:0], sh_q[6]};
      if (cnt_q == sfl_front_pkg::ADDR_LAST_BIT) begin
        adr_tg_q <= !adr_tg_q;
        adr_page_q <= dec_page;
        adr_byte_q <= dec_byte;
        adr_buf_q <= dec_buf;
      end
    end
  end

  // Array read enable and bit counter; set at the last dummy bit, stepped per bit
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      ARRAY_RD <= 1'b0;
      bit_q <= '0;
    end else if (rs2_q) begin
      ARRAY_RD <= 1'b0;
      bit_q <= '0;
    end else if (state_q == sfl_front_pkg::ST_DUMMY &&
                 cnt_q == sfl_front_pkg::DUMMY_LAST_BIT) begin
      ARRAY_RD <= 1'b1;
      bit_q <= '0;
    end else if (state_q == sfl_front_pkg::ST_DATA) begin
      bit_q <= bit_q + 3'h1;
    end
  end

  // Pointer fields keep their value across frames; nothing reads them then
  always_ff @(posedge SCK) begin
    if (rs2_q) begin
      ARRAY_PAGE <= '0;
      ARRAY_BYTE <= '0;
    end else if (!CS_N && state_q == sfl_front_pkg::ST_DUMMY &&
                 cnt_q == sfl_front_pkg::DUMMY_LAST_BIT) begin
      ARRAY_PAGE <= adr_page_q;
      ARRAY_BYTE <= adr_byte_q;
    end else if (!CS_N && state_q == sfl_front_pkg::ST_DATA &&
                 bit_q == sfl_front_pkg::BYTE_LAST_BIT) begin
      if (ARRAY_BYTE >= byte_last) begin
        ARRAY_BYTE <= '0;
        // Page number simply rolls over past the last of 2048 pages
        if (ARRAY_PAGE == sfl_front_pkg::PAGE_LAST) begin
          ARRAY_PAGE <= '0;
        end else begin
          ARRAY_PAGE <= ARRAY_PAGE + 11'h001;
        end
      end else begin
        ARRAY_BYTE <= ARRAY_BYTE + 9'h001;
      end
    end
  end

  // Output shifter on the falling edge; a fresh byte at bit 0
  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      SO <= 1'b0;
      SO_OE <= 1'b0;
      so_sh_q <= '0;
    end else if (rs2_q || state_q != sfl_front_pkg::ST_DATA) begin
      SO <= 1'b0;
      SO_OE <= 1'b0;
      so_sh_q <= '0;
    end else if (bit_q == 3'h0) begin
      SO <= ARRAY_DATA[7];
      SO_OE <= 1'b1;
      so_sh_q <= {ARRAY_DATA[6:0], 1'b0};
    end else begin
      SO <= so_sh_q[7];
      SO_OE <= 1'b1;
      so_sh_q <= {so_sh_q[6:0], 1'b0};
    end
  end

  // Toggle events into the reference domain; third stage detects edges
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      opc_tg_r_q <= '0;
      adr_tg_r_q <= '0;
    end else begin
      opc_tg_r_q <= {opc_tg_r_q[1:0], opc_tg_q};
      adr_tg_r_q <= {adr_tg_r_q[1:0], adr_tg_q};
    end
  end

  // Command report; the link word is stable long before the toggle lands
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      CMD_STROBE <= 1'b0;
      CMD_OPCODE <= '0;
      CMD_WRITE <= 1'b0;
      CMD_BLOCKED <= 1'b0;
      CMD_PROTECT <= 1'b0;
    end else begin
      // Link reset clears the toggle; that edge is no command
      CMD_STROBE <= (opc_tg_r_q[2] ^ opc_tg_r_q[1]) && !core_rst_q;
      if ((opc_tg_r_q[2] ^ opc_tg_r_q[1]) && !core_rst_q) begin
        CMD_OPCODE <= opc_word_q;
        CMD_WRITE <= opc_wr_q;
        CMD_BLOCKED <= opc_blk_q;
        CMD_PROTECT <= opc_prot_q;
      end
    end
  end

  // Address report for every command that got past its opcode and all three address bytes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ADDR_STROBE <= 1'b0;
      ADDR_PAGE <= '0;
      ADDR_BYTE <= '0;
      ADDR_BUF_BYTE <= '0;
    end else begin
      ADDR_STROBE <= (adr_tg_r_q[2] ^ adr_tg_r_q[1]) && !core_rst_q;
      if ((adr_tg_r_q[2] ^ adr_tg_r_q[1]) && !core_rst_q) begin
        ADDR_PAGE <= adr_page_q;
        ADDR_BYTE <= adr_byte_q;
        ADDR_BUF_BYTE <= adr_buf_q;
      end
    end
  end
endmodule

// ---- core/sfl_front_pkg.sv ----
/*
  Constants for the serial flash command front end: continuous read opcode,
  framing counts, address field layout, page limits and reset timing.
  Assumes a 25 MHz reference clock and an SPI mode 0/3 host.
*/
// Functional notes
// - Write-guard low discards program and erase commands; idle again at chip-select high.
// - Sector protection enable and lockdown stay accepted while write-guard is low.
// - Reset pin low aborts any operation and holds the state machine idle.
// - Own power-on reset; reset pin needs no power-up sequencing.
// - Instruction starts at chip-select fall, then 8-bit opcode, then address.
// - Opcode and address shift in on serial input only while selected.
// - Opcodes, addresses and data travel most significant bit first.
// - Memory accesses carry three address bytes; leading bits may be don't-care.
// - Standard page size selects buffer bytes by a 9-bit address.
// - Standard page: 11-bit page number then 9-bit byte offset.
// - Binary page size selects buffer bytes by an 8-bit address.
// - Binary page: 19-bit linear address, upper 11 page, lower 8 byte.
// - Opcode e8, three address bytes, four dummy bytes, then data out.
// - Internal address counter advances by itself during continuous read.
// - Page end rolls into next page start with no gap.
// - Array end wraps to first page start with no gap.
// - Chip-select rise ends the read and floats the serial output.
// - Continuous read fetches straight from the array, buffers untouched.
// - Program and erase exist at chip, sector, block and page grain.
// - Inputs sampled on clock rise; outputs driven on clock fall.
// - Deselected: serial input ignored, output floats, standby entered.
// - Array has 2048 pages of 256 or 264 bytes.
// - Protection register cannot change once write-guard is low.
package sfl_front_pkg;
  localparam logic [7:0] OPC_CONT_READ = 8'he8;
  localparam logic [5:0] OPC_LAST_BIT = 6'h07;
  localparam logic [5:0] ADDR_LAST_BIT = 6'h1f;
  localparam logic [5:0] DUMMY_LAST_BIT = 6'h3f;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  // Address field positions in the 24-bit address word
  localparam int STD_PAGE_LSB = 9;
  localparam int BIN_PAGE_LSB = 8;
  localparam int PAGE_W = 11;
  localparam int BYTE_W = 9;
  localparam logic [8:0] STD_BYTE_LAST = 9'h107;
  localparam logic [8:0] BIN_BYTE_LAST = 9'h0ff;
  localparam logic [10:0] PAGE_LAST = 11'h7ff;
  // Power-on reset stretch
  localparam int REF_CLK_PERIOD_NS = 40;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam logic [5:0] POR_COUNT = 6'(POR_CYCLES);
  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b011,
    ST_DATA = 3'b010,
    ST_DROP = 3'b110
  } link_state_t;
endpackage

// ---- tb/sfl_front_chk.sv ----
/*
  Checker for sfl_front: report pulses, write guard, reset, read pointer walk.
  Assumes it is bound to sfl_front and sees only its ports.
*/
`timescale 1ns/1ps
module sfl_front_chk (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic WP_N,
  input wire logic RESET_N,
  input wire logic PAGE_BIN,
  input wire logic SO_OE,
  input wire logic ARRAY_RD,
  input wire logic [10:0] ARRAY_PAGE,
  input wire logic [8:0] ARRAY_BYTE,
  input wire logic CMD_STROBE,
  input wire logic CMD_WRITE,
  input wire logic CMD_BLOCKED,
  input wire logic CMD_PROTECT,
  input wire logic ADDR_STROBE,
  input wire logic PROT_REG_LOCK,
  input wire logic STANDBY,
  input wire logic CORE_RESET
);
  // Report side
  property p_cmd_pulse;
    @(posedge REF_CLK) disable iff (RST) CMD_STROBE |=> !CMD_STROBE;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("strobe too long");
  property p_wp_block;
    @(posedge REF_CLK) disable iff (RST) !WP_N [*8] ##1 CMD_STROBE |-> !CMD_WRITE;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("write taken while guarded");
  property p_no_addr;
    @(posedge REF_CLK) disable iff (RST) ADDR_STROBE |-> !CMD_BLOCKED;
  endproperty
  a_no_addr: assert property (p_no_addr) else $error("address after discard");
  property p_prot;
    @(posedge REF_CLK) disable iff (RST) CMD_STROBE && CMD_PROTECT |-> !CMD_BLOCKED;
  endproperty
  a_prot: assert property (p_prot) else $error("protect command discarded");
  // Lag of the synchronisers bounds these windows
  property p_lock;
    @(posedge REF_CLK) disable iff (RST) $fell(WP_N) |-> ##[1:5] PROT_REG_LOCK;
  endproperty
  a_lock: assert property (p_lock) else $error("lock late");
  property p_reset_pin;
    @(posedge REF_CLK) disable iff (RST) !RESET_N [*5] |-> CORE_RESET;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
  property p_standby;
    @(posedge REF_CLK) disable iff (RST) CS_N [*6] |-> STANDBY;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby");
  // Link side: pointer steps by one byte, pages roll, array wraps
  property p_ptr_step;
    @(posedge SCK) disable iff (CS_N || RST)
      ARRAY_RD && $past(ARRAY_RD) && ARRAY_BYTE != $past(ARRAY_BYTE) |->
      ARRAY_BYTE == $past(ARRAY_BYTE) + 9'h1 ||
      (ARRAY_BYTE == 9'h0 && ARRAY_PAGE == $past(ARRAY_PAGE) + 11'h1);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("bad pointer step");
  property p_page_end;
    @(posedge SCK) disable iff (CS_N || RST)
      ARRAY_RD && $past(ARRAY_RD) && ARRAY_BYTE != $past(ARRAY_BYTE) &&
      $past(ARRAY_BYTE) == (PAGE_BIN ? 9'h0ff : 9'h107) |-> ARRAY_BYTE == 9'h0;
  endproperty
  a_page_end: assert property (p_page_end) else $error("page end missed");
  property p_oe;
    @(posedge SCK) disable iff (CS_N || RST) SO_OE |-> ARRAY_RD;
  endproperty
  a_oe: assert property (p_oe) else $error("output outside data phase");
  c_blocked: cover property (@(posedge REF_CLK) CMD_STROBE && CMD_BLOCKED);
  c_protect: cover property (@(posedge REF_CLK) ADDR_STROBE && CMD_PROTECT);
  c_wrap: cover property (@(posedge SCK) ARRAY_RD && ARRAY_PAGE == 11'h0 && ARRAY_BYTE == 9'h0);
endmodule

bind sfl_front sfl_front_chk chk_u (.REF_CLK(REF_CLK), .RST(RST), .SCK(SCK), .CS_N(CS_N),
  .WP_N(WP_N), .RESET_N(RESET_N), .PAGE_BIN(PAGE_BIN), .SO_OE(SO_OE), .ARRAY_RD(ARRAY_RD),
  .ARRAY_PAGE(ARRAY_PAGE), .ARRAY_BYTE(ARRAY_BYTE), .CMD_STROBE(CMD_STROBE),
  .CMD_WRITE(CMD_WRITE), .CMD_BLOCKED(CMD_BLOCKED), .CMD_PROTECT(CMD_PROTECT),
  .ADDR_STROBE(ADDR_STROBE), .PROT_REG_LOCK(PROT_REG_LOCK), .STANDBY(STANDBY),
  .CORE_RESET(CORE_RESET));

// ---- tb/sfl_host_model.sv ----
/*
  Host controller model, SPI mode 0, 64 ns serial period.
  Serial clock stays low between frames; the bench calls frame().
*/
`timescale 1ns/1ps
module sfl_host_model (
  output logic SCK,
  output logic CS_N,
  output logic SI,
  input wire logic SO
);
  logic [7:0] rd_q[$];
  logic [7:0] sh;
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
  end
  // Header bits MSB first, then nrd bytes read back; select held throughout
  task automatic frame(input logic [63:0] hdr, input int n, input int nrd);
    int i;
    #13 CS_N <= 1'b0;
    for (i = 0; i < n + 8 * nrd; i++) begin
      SI <= (i < n) ? hdr[63 - i] : ~SI;
      #32;
      if (i >= n) begin
        sh = {sh[6:0], SO};
        if ((i - n) % 8 == 7)
          rd_q.push_back(sh);
      end
      SCK <= 1'b1;
      #32 SCK <= 1'b0;
    end
    #32 CS_N <= 1'b1;
    SI <= ~SI; // Junk on a line the device must ignore
    #240;
  endtask
endmodule

// ---- tb/tb_top.sv ----
/*
  Bench for sfl_front: command reports from a table, then reads across
  page and array ends and the reset pin. Array is a formula here.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] opc;
    logic wp_n;
    logic bin;
    logic [23:0] a;
    logic [2:0] wbp;
  } row_t;
  // Opcode, guard, page size, address, expected write/blocked/protect
  row_t rows[5] = '{
    '{8'h82, 1'b1, 1'b0, 24'hf0_f3_07, 3'h4},
    '{8'h82, 1'b0, 1'b0, 24'h01_2345, 3'h2},
    '{8'h3d, 1'b0, 1'b1, 24'h0a_bc12, 3'h1},
    '{8'h52, 1'b1, 1'b1, 24'hf5_a3c7, 3'h0},
    '{8'h8f, 1'b1, 1'b1, 24'h07_ff80, 3'h4}};
  logic REF_CLK, RST, WP_N, RESET_N, PAGE_BIN, SO, SO_OE, ARRAY_RD, CMD_STROBE;
  logic CMD_WRITE, CMD_BLOCKED, CMD_PROTECT, ADDR_STROBE, PROT_REG_LOCK, STANDBY, CORE_RESET;
  logic [10:0] ARRAY_PAGE, ADDR_PAGE;
  logic [8:0] ARRAY_BYTE, ADDR_BYTE, ADDR_BUF_BYTE;
  logic [7:0] ARRAY_DATA, CMD_OPCODE;
  wire SCK, CS_N, SI;
  int errors, n_checks, n_cmd, n_addr, c, k;
  sfl_front dut_u (.REF_CLK(REF_CLK), .RST(RST), .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO),
    .SO_OE(SO_OE), .WP_N(WP_N), .RESET_N(RESET_N), .PAGE_BIN(PAGE_BIN),
    .ARRAY_PAGE(ARRAY_PAGE), .ARRAY_BYTE(ARRAY_BYTE), .ARRAY_RD(ARRAY_RD),
    .ARRAY_DATA(ARRAY_DATA), .CMD_STROBE(CMD_STROBE), .CMD_OPCODE(CMD_OPCODE),
    .CMD_WRITE(CMD_WRITE), .CMD_BLOCKED(CMD_BLOCKED), .CMD_PROTECT(CMD_PROTECT),
    .ADDR_STROBE(ADDR_STROBE), .ADDR_PAGE(ADDR_PAGE), .ADDR_BYTE(ADDR_BYTE),
    .ADDR_BUF_BYTE(ADDR_BUF_BYTE), .PROT_REG_LOCK(PROT_REG_LOCK), .STANDBY(STANDBY),
    .CORE_RESET(CORE_RESET));
  sfl_host_model host_u (.SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO));
  // Array contents: distinct across page ends so a missed roll shows
  assign ARRAY_DATA = 8'(ARRAY_PAGE * 11'h3 + 11'(ARRAY_BYTE));
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  // Report strobes counted as they pass
  always @(posedge REF_CLK) begin
    if (CMD_STROBE === 1'b1) n_cmd++;
    if (ADDR_STROBE === 1'b1) n_addr++;
  end
  task automatic chk_v(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Pins move only between frames; six cycles let the synchronisers settle
  task automatic drive(input logic wp, input logic bin, input logic rn);
    @(posedge REF_CLK);
    WP_N <= wp;
    PAGE_BIN <= bin;
    RESET_N <= rn;
    repeat (6) @(posedge REF_CLK);
  endtask
  // Bounded wait, then a spare frame so the link side sees reset gone
  task automatic wait_rdy;
    k = 0;
    while (CORE_RESET !== 1'b0 && k < 100) begin
      @(posedge REF_CLK);
      k++;
    end
    chk_v(11'(k < 100), 11'h1);
    host_u.frame(64'h0, 8, 0);
  endtask
  // Continuous read with don't-care address bits set and junk dummies
  task automatic rd(input logic bin, input logic [10:0] p, input logic [8:0] b, input int nb);
    int j;
    drive(1'b1, bin, 1'b1);
    host_u.rd_q.delete();
    host_u.frame({8'he8, bin ? {5'h1f, p, b[7:0]} : {4'hf, p, b}, 32'h5a5a_c3c3}, 64, nb);
    for (j = 0; j < nb; j++) begin
      chk_v(11'(host_u.rd_q[j]), 11'(8'(p * 11'h3 + 11'(b))));
      b = (b == (bin ? 9'h0ff : 9'h107)) ? 9'h0 : b + 9'h1;
      if (b == 9'h0) p = p + 11'h1;
    end
    chk_v(11'(SO_OE), 11'h0);
  endtask
  initial begin
    RST = 1'b1;
    WP_N = 1'b1;
    RESET_N = 1'b1;
    PAGE_BIN = 1'b0;
    repeat (6) @(posedge REF_CLK);
    // Clock the link once in reset so its toggles leave the unknown state
    host_u.frame(64'h0, 8, 0);
    RST <= 1'b0;
    wait_rdy();
    foreach (rows[i]) begin
      drive(rows[i].wp_n, rows[i].bin, 1'b1);
      c = n_addr;
      host_u.frame({rows[i].opc, rows[i].a, 32'h0}, 32, 0);
      chk_v(11'(CMD_OPCODE), 11'(rows[i].opc));
      chk_v(11'({CMD_WRITE, CMD_BLOCKED, CMD_PROTECT}), 11'(rows[i].wbp));
      chk_v(11'(PROT_REG_LOCK), 11'(!rows[i].wp_n));
      chk_v(11'(n_addr - c), 11'(!rows[i].wbp[1]));
      if (!rows[i].wbp[1]) begin
        chk_v(ADDR_PAGE, rows[i].bin ? rows[i].a[18:8] : rows[i].a[19:9]);
        chk_v(11'(ADDR_BYTE), 11'(rows[i].bin ? {1'b0, rows[i].a[7:0]} : rows[i].a[8:0]));
        chk_v(11'(ADDR_BUF_BYTE), 11'(rows[i].bin ? rows[i].a[7:0] : rows[i].a[8:0]));
      end
      chk_v(11'(STANDBY), 11'h1);
    end
    rd(1'b0, 11'h7ff, 9'h106, 3);
    rd(1'b1, 11'h005, 9'h0fe, 3);
    rd(1'b1, 11'h7ff, 9'h0ff, 2);
    drive(1'b1, 1'b0, 1'b0);
    chk_v(11'(CORE_RESET), 11'h1);
    c = n_cmd;
    host_u.frame({8'h82, 24'h00_0100, 32'h0}, 32, 0);
    chk_v(11'(n_cmd - c), 11'h0);
    drive(1'b1, 1'b0, 1'b1);
    wait_rdy();
    rd(1'b0, 11'h123, 9'h000, 2);
    wrap_up();
  end
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
endmodule
